//--- design/tmr_pkg.sv
// package for the trigger and min/max recorder: register map, fields, timing, types
// assumes a 125 MHz ref_clk and a 32-bit avalon-mm register port
package tmr_pkg;
  localparam int NCH = 4;
  localparam int DW = 16;
  localparam int FAST_CH_A = 0;
  localparam int FAST_CH_B = 1;
  localparam int AW = 8;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS = 100000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_US = 100;
  localparam int STD_MIN_PERIOD_US = 1000;
  localparam logic [15:0] STD_MIN_TICKS = 16'(STD_MIN_PERIOD_US / TICK_US);
  localparam int MS_US = 1000;
  localparam logic [3:0] MS_TICKS = 4'(MS_US / TICK_US);
  localparam int RAPID_LIMIT_S = 120;
  localparam logic [31:0] RAPID_LIMIT_TICKS = 32'(RAPID_LIMIT_S * (1000000 / TICK_US));
  // register byte offsets
  localparam logic [AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AW-1:0] REG_TRIG_TIME = 8'h04;
  localparam logic [AW-1:0] REG_SYS_TIME = 8'h08;
  localparam logic [AW-1:0] REG_DURATION = 8'h0C;
  localparam logic [AW-1:0] REG_INTERVAL = 8'h10;
  localparam logic [AW-1:0] REG_PERIOD = 8'h14;
  localparam logic [AW-1:0] REG_STATUS = 8'h18;
  localparam logic [1:0] RES_PAGE = 2'h1;
  // control and status fields
  localparam int CB_ARM = 0;
  localparam int CB_ABORT = 1;
  localparam int CB_MODE_A = 2;
  localparam int CB_EDGE_RISE = 4;
  localparam int CB_STOP_DUR = 5;
  localparam int CB_RAPID = 6;
  localparam int CB_LOGIC = 7;
  localparam int CB_LOGIC_AND = 8;
  localparam int CB_MODE_B = 9;
  localparam int SB_ERR = 8;
  localparam int SB_DONE = 9;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] PERIOD_RST = 16'h000A;
  localparam logic [15:0] INTERVAL_RST = 16'h0001;

  typedef enum logic [1:0] {SM_CAL = 2'h0, SM_EDGE = 2'h1, SM_KEY = 2'h2} tmr_smode_t;
  typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_ARMED = 3'h2, ST_REC = 3'h4} tmr_state_t;
  typedef struct packed {
    logic [DW-1:0] cur;
    logic [DW-1:0] lo;
    logic [DW-1:0] hi;
  } tmr_rec_t;
endpackage

//--- design/tmr_top.sv
// trigger control and per-interval current/min/max reduction for the sensor channels
// assumes synchronous inputs on ref_clk, an avalon-mm master and a seconds-based sys_time
//
// Contract
// - calendar mode starts at configured system time
// - edge mode starts on matching input edge
// - pre-existing input level never starts recording
// - start key starts recording, no parameters
// - duration stop ends after configured time
// - duration also limits logic-combined recordings
// - all channels sampled on common tick
// - standard format period at least 1 ms
// - current value is interval's last sample
// - lowest value is interval minimum
// - highest value is interval maximum
// - one triple saved per configured interval
// - rapid format saves fast channels every 0.1 ms
// - rapid format ignores all other channels
// - rapid format refused for logic-combined recordings
// - rapid recording stops at 120 seconds
// - AND-combined conditions must occur sequentially
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
module tmr_top #(
  parameter int TICK_CYCLES = tmr_pkg::TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [tmr_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [31:0] sys_time,
  input wire logic ext_din,
  input wire logic operator_start_key,
  input wire logic [tmr_pkg::NCH-1:0][tmr_pkg::DW-1:0] chan_in,
  output logic recording,
  output logic [tmr_pkg::NCH-1:0] chan_active,
  output logic rec_valid,
  output tmr_pkg::tmr_rec_t [tmr_pkg::NCH-1:0] rec_data
);
  import tmr_pkg::*;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic cond_hit(input logic [1:0] m, input logic cal, input logic edg,
                                    input logic key);
    logic r;
    r = 1'b0;
    unique case (m)
      SM_CAL: r = cal;
      SM_EDGE: r = edg;
      SM_KEY: r = key;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  tmr_state_t state_r;
  logic ack_r;
  logic [31:0] rd_nxt;
  logic [31:0] ctrl_r, trig_time_r, duration_r;
  logic [15:0] interval_r, period_r;
  logic err_r, done_r;
  logic din_prev_r, key_prev_r, a_seen_r, b_seen_r;
  logic [31:0] tick_cnt_r, rec_ticks_r, ms_cnt_r;
  logic [3:0] ms_sub_r;
  logic [15:0] per_cnt_r, int_cnt_r;
  logic first_r, tick, samp_en, int_end;
  logic [15:0] eff_per, eff_int;
  logic cal_hit, edge_hit, key_hit, hit_a, hit_b, fire, stop;
  logic wr_ack, wr_ctrl, arm_w, abort_w;
  logic rapid, logic_m;

  assign rapid = ctrl_r[CB_RAPID];
  assign logic_m = ctrl_r[CB_LOGIC];
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_ack = avs_write & ack_r;
  assign wr_ctrl = wr_ack & (avs_address == REG_CTRL) & avs_byteenable[0];
  assign arm_w = wr_ctrl & avs_writedata[CB_ARM];
  assign abort_w = wr_ctrl & avs_writedata[CB_ABORT];
  assign recording = (state_r == ST_REC);

  // bus slave: one wait cycle, then answer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
      if (avs_read & ~ack_r) begin
        avs_readdata <= rd_nxt;
      end
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (avs_address[7:6] == RES_PAGE) begin
      unique case (avs_address[3:2])
        2'h0: rd_nxt = {16'h0000, rec_data[avs_address[5:4]].cur};
        2'h1: rd_nxt = {16'h0000, rec_data[avs_address[5:4]].lo};
        2'h2: rd_nxt = {16'h0000, rec_data[avs_address[5:4]].hi};
        default: rd_nxt = 32'h0000_0000;
      endcase
    end else begin
      unique case (avs_address)
        REG_CTRL: rd_nxt = {ctrl_r[31:2], 2'h0};
        REG_TRIG_TIME: rd_nxt = trig_time_r;
        REG_SYS_TIME: rd_nxt = sys_time;
        REG_DURATION: rd_nxt = duration_r;
        REG_INTERVAL: rd_nxt = {16'h0000, interval_r};
        REG_PERIOD: rd_nxt = {16'h0000, period_r};
        REG_STATUS: rd_nxt = {22'h000000, done_r, err_r, 5'h00, state_r};
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  // configuration writes, locked while armed or recording
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
      trig_time_r <= 32'h0000_0000;
      duration_r <= 32'h0000_0000;
      interval_r <= INTERVAL_RST;
      period_r <= PERIOD_RST;
    end else if (wr_ack && state_r == ST_IDLE) begin
      unique case (avs_address)
        REG_CTRL: ctrl_r <= be_merge(ctrl_r, avs_writedata, avs_byteenable);
        REG_TRIG_TIME: trig_time_r <= be_merge(trig_time_r, avs_writedata, avs_byteenable);
        REG_DURATION: duration_r <= be_merge(duration_r, avs_writedata, avs_byteenable);
        REG_INTERVAL: interval_r <= 16'(be_merge({16'h0000, interval_r}, avs_writedata,
                                                 avs_byteenable));
        REG_PERIOD: period_r <= 16'(be_merge({16'h0000, period_r}, avs_writedata,
                                             avs_byteenable));
        default: ;
      endcase
    end
  end

  // start condition detection
  assign cal_hit = (sys_time >= trig_time_r);
  assign edge_hit = ctrl_r[CB_EDGE_RISE] ? (ext_din & ~din_prev_r)
                                         : (~ext_din & din_prev_r);
  assign key_hit = operator_start_key & ~key_prev_r;
  assign hit_a = cond_hit(ctrl_r[CB_MODE_A +: 2], cal_hit, edge_hit, key_hit);
  assign hit_b = cond_hit(ctrl_r[CB_MODE_B +: 2], cal_hit, edge_hit, key_hit);

  always_comb begin
    if (!logic_m) begin
      fire = hit_a;
    end else if (ctrl_r[CB_LOGIC_AND]) begin
      fire = (hit_a & ~hit_b & b_seen_r) | (hit_b & ~hit_a & a_seen_r);
    end else begin
      fire = hit_a | hit_b;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      din_prev_r <= 1'b0;
      key_prev_r <= 1'b0;
      a_seen_r <= 1'b0;
      b_seen_r <= 1'b0;
    end else begin
      din_prev_r <= ext_din;
      key_prev_r <= operator_start_key;
      a_seen_r <= (state_r == ST_ARMED) & (a_seen_r | hit_a);
      b_seen_r <= (state_r == ST_ARMED) & (b_seen_r | hit_b);
    end
  end

  // stop: duration, rapid limit, abort
  assign stop = abort_w
              | ((ctrl_r[CB_STOP_DUR] | logic_m) & (duration_r != 32'h0000_0000)
                 & (ms_cnt_r >= duration_r))
              | (rapid & (rec_ticks_r >= RAPID_LIMIT_TICKS));

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      err_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (arm_w) begin
            err_r <= avs_writedata[CB_RAPID] & avs_writedata[CB_LOGIC];
            done_r <= 1'b0;
            if (!(avs_writedata[CB_RAPID] & avs_writedata[CB_LOGIC])) begin
              state_r <= ST_ARMED;
            end
          end
        end
        ST_ARMED: begin
          if (abort_w) begin
            state_r <= ST_IDLE;
          end else if (fire) begin
            state_r <= ST_REC;
          end
        end
        ST_REC: begin
          if (stop) begin
            state_r <= ST_IDLE;
            done_r <= 1'b1;
          end
        end
      endcase
    end
  end

  // common sampling tick and recording timers
  assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));
  assign eff_per = rapid ? 16'h0001
                 : ((period_r < STD_MIN_TICKS) ? STD_MIN_TICKS : period_r);
  assign eff_int = (rapid || interval_r == 16'h0000) ? 16'h0001 : interval_r;
  assign samp_en = recording & tick & (per_cnt_r == eff_per - 16'h0001);
  assign int_end = samp_en & (int_cnt_r == eff_int - 16'h0001);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= 32'h0000_0000;
    end else begin
      tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rec_ticks_r <= 32'h0000_0000;
      ms_cnt_r <= 32'h0000_0000;
      ms_sub_r <= 4'h0;
      per_cnt_r <= 16'h0000;
      int_cnt_r <= 16'h0000;
    end else if (!recording) begin
      rec_ticks_r <= 32'h0000_0000;
      ms_cnt_r <= 32'h0000_0000;
      ms_sub_r <= 4'h0;
      per_cnt_r <= 16'h0000;
      int_cnt_r <= 16'h0000;
    end else if (tick) begin
      rec_ticks_r <= rec_ticks_r + 32'h0000_0001;
      ms_sub_r <= (ms_sub_r == MS_TICKS - 4'h1) ? 4'h0 : ms_sub_r + 4'h1;
      if (ms_sub_r == MS_TICKS - 4'h1) begin
        ms_cnt_r <= ms_cnt_r + 32'h0000_0001;
      end
      per_cnt_r <= samp_en ? 16'h0000 : per_cnt_r + 16'h0001;
      if (samp_en) begin
        int_cnt_r <= int_end ? 16'h0000 : int_cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      first_r <= 1'b1;
      rec_valid <= 1'b0;
    end else begin
      first_r <= !recording | int_end | (first_r & ~samp_en);
      rec_valid <= int_end;
    end
  end

  // per-channel reduction
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [DW-1:0] lo_r, hi_r, lo_n, hi_n;
    logic en;
    assign en = ~rapid | (i == FAST_CH_A) | (i == FAST_CH_B);
    assign chan_active[i] = recording & en;
    assign lo_n = (first_r || chan_in[i] < lo_r) ? chan_in[i] : lo_r;
    assign hi_n = (first_r || chan_in[i] > hi_r) ? chan_in[i] : hi_r;
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        lo_r <= '0;
        hi_r <= '0;
        rec_data[i] <= '0;
      end else if (samp_en && en) begin
        lo_r <= lo_n;
        hi_r <= hi_n;
        if (int_end) begin
          rec_data[i] <= '{cur: chan_in[i], lo: lo_n, hi: hi_n};
        end
      end
    end
  end

  // checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [31:0] gap_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gap_r <= 32'h0000_0000;
    end else begin
      gap_r <= samp_en ? 32'h0000_0001 : gap_r + 32'h0000_0001;
    end
  end

  AST_CAL_START: assert property (state_r == ST_ARMED && !logic_m && !abort_w &&
      ctrl_r[CB_MODE_A +: 2] == SM_CAL && sys_time >= trig_time_r |=> state_r == ST_REC)
    else $error("calendar start missed");
  AST_EDGE_START: assert property (state_r == ST_ARMED && !logic_m && !abort_w &&
      ctrl_r[CB_MODE_A +: 2] == SM_EDGE && ctrl_r[CB_EDGE_RISE] && $rose(ext_din)
      |=> state_r == ST_REC)
    else $error("rising edge start missed");
  AST_NO_LEVEL: assert property (state_r == ST_ARMED && !logic_m &&
      ctrl_r[CB_MODE_A +: 2] == SM_EDGE && $stable(ext_din) |=> state_r != ST_REC)
    else $error("static level started recording");
  AST_KEY_START: assert property (state_r == ST_ARMED && !logic_m && !abort_w &&
      ctrl_r[CB_MODE_A +: 2] == SM_KEY && $rose(operator_start_key) |=> recording)
    else $error("key start missed");
  AST_DUR_STOP: assert property (recording && ctrl_r[CB_STOP_DUR] && duration_r != 0 &&
      ms_cnt_r >= duration_r |=> state_r == ST_IDLE ##1 !recording)
    else $error("duration stop missed");
  AST_MIN_PERIOD: assert property (samp_en && !rapid && $past(recording, 2) &&
      !first_r |-> gap_r >= 32'(int'(STD_MIN_TICKS) * TICK_CYCLES))
    else $error("standard sample period below minimum");
  AST_ORDER: assert property (rec_valid |-> rec_data[0].lo <= rec_data[0].cur &&
      rec_data[0].cur <= rec_data[0].hi)
    else $error("interval triple out of order");
  AST_RAPID_ONLY: assert property (recording && rapid |->
      chan_active == NCH'((1 << FAST_CH_A) | (1 << FAST_CH_B)))
    else $error("non-fast channel active in rapid format");
  AST_RAPID_LOGIC: assert property (state_r != ST_IDLE |-> !(rapid && logic_m))
    else $error("rapid format with logic recording");
  AST_RAPID_LIMIT: assert property (recording && rapid |-> rec_ticks_r <= RAPID_LIMIT_TICKS)
    else $error("rapid recording exceeded limit");
  AST_AND_SEQ: assert property (state_r == ST_ARMED && logic_m && ctrl_r[CB_LOGIC_AND] &&
      hit_a && hit_b && !a_seen_r && !b_seen_r |=> state_r != ST_REC)
    else $error("simultaneous and-conditions fired");
endmodule

//--- bench/tmr_sensor_model.sv
// partner model: sensor channels and the digital input line in front of the recorder
// assumes the bench sets the wanted levels; they reach the pins at the next ref_clk edge
`timescale 1ns/10ps
module tmr_sensor_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [tmr_pkg::NCH-1:0][tmr_pkg::DW-1:0] want_val,
  input wire logic want_din,
  output logic [tmr_pkg::NCH-1:0][tmr_pkg::DW-1:0] chan_in,
  output logic ext_din
);
  import tmr_pkg::*;
  // sensors present a steady value between updates, as a held sample would
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chan_in <= '0;
      ext_din <= 1'b0;
    end else begin
      chan_in <= want_val;
      ext_din <= want_din;
    end
  end
endmodule

//--- bench/tb_top.sv
// self-checking bench for the trigger and min/max recorder
// assumes tmr_top with a short tick; registers reached over avalon-mm
`timescale 1ns/10ps
module tb_top;
  import tmr_pkg::*;
  localparam int TK = 4;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [AW-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] sys_time = 32'h0000_0100;
  logic want_din = 1'b0;
  logic operator_start_key = 1'b0;
  logic [NCH-1:0][DW-1:0] want_val = '0;
  logic [NCH-1:0][DW-1:0] chan_in;
  logic ext_din;
  logic recording;
  logic [NCH-1:0] chan_active;
  logic rec_valid;
  tmr_rec_t [NCH-1:0] rec_data;
  logic [31:0] seed = 32'hC741;
  int mismatches = 0;
  int checks = 0;

  always #4 ref_clk = ~ref_clk;

  tmr_sensor_model model_u (.ref_clk(ref_clk), .rst(rst), .want_val(want_val),
    .want_din(want_din), .chan_in(chan_in), .ext_din(ext_din));
  tmr_top #(.TICK_CYCLES(TK)) dut_u (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sys_time(sys_time), .ext_din(ext_din), .operator_start_key(operator_start_key),
    .chan_in(chan_in), .recording(recording), .chan_active(chan_active),
    .rec_valid(rec_valid), .rec_data(rec_data));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    logic w;
    int i;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    w = 1'b1;
    for (i = 0; i < 50 && w; i++) begin
      @(posedge ref_clk);
      w = avs_waitrequest;
      q = avs_readdata;
    end
    if (w !== 1'b0) begin
      mismatches++;
      $display("Error at %0t: bus request not answered", $time);
      end_of_test();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [AW-1:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask

  // v selects rec_valid, else recording; n counts negedges waited
  task automatic wait_on(input bit v, input logic lvl, input int lim, output int n);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
      if (n > lim) begin
        mismatches++;
        $display("Error at %0t: wait timed out", $time);
        end_of_test();
      end
    end while ((v ? rec_valid : recording) !== lvl);
  endtask

  task automatic press();
    @(posedge ref_clk);
    operator_start_key <= 1'b1;
    repeat (2) @(posedge ref_clk);
    operator_start_key <= 1'b0;
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    mismatches++;
    $display("Error at %0t: run limit reached", $time);
    end_of_test();
  end

  initial begin
    int n;
    logic [31:0] q;
    logic [31:0] t;
    logic [15:0] ec [NCH];
    logic [15:0] el [NCH];
    logic [15:0] eh [NCH];
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rd(REG_STATUS, q);
    chk(q & 32'h0000_0007, 32'h0000_0001);
    rd(REG_PERIOD, q);
    chk(q, {16'h0000, PERIOD_RST});
    rd(REG_INTERVAL, q);
    chk(q, {16'h0000, INTERVAL_RST});
    rd(REG_CTRL, q);
    chk(q, CTRL_RST);
    rd(8'h3C, q);
    chk(q, 32'h0000_0000);
    wr(REG_CTRL, 32'h0000_00C1);
    rd(REG_STATUS, q);
    chk(q & 32'h0000_0107, 32'h0000_0101);
    // standard format, three samples per interval, random samples
    wr(REG_INTERVAL, 32'h0000_0003);
    wr(REG_CTRL, 32'h0000_0009);
    press();
    wait_on(0, 1'b1, 20, n);
    chk(32'(chan_active), 32'h0000_000F);
    wait_on(1, 1'b1, 300, n);
    repeat (3) begin
      for (int k = 0; k < 3; k++) begin
        repeat (20) @(posedge ref_clk);
        for (int c = 0; c < NCH; c++) begin
          t = rnd();
          want_val[c] <= t[15:0];
          ec[c] = t[15:0];
          el[c] = (k == 0 || t[15:0] < el[c]) ? t[15:0] : el[c];
          eh[c] = (k == 0 || t[15:0] > eh[c]) ? t[15:0] : eh[c];
        end
        if (k < 2) begin
          repeat (20) @(posedge ref_clk);
        end else begin
          wait_on(1, 1'b1, 60, n);
        end
      end
      for (int c = 0; c < NCH; c++) begin
        chk(32'(rec_data[c].cur), 32'(ec[c]));
        chk(32'(rec_data[c].lo), 32'(el[c]));
        chk(32'(rec_data[c].hi), 32'(eh[c]));
      end
    end
    wr(REG_CTRL, 32'h0000_0002);
    wait_on(0, 1'b0, 10, n);
    // rapid format: only the two fast channels, one value per tick
    ec[2] = rec_data[2].cur;
    ec[3] = rec_data[3].cur;
    wr(REG_CTRL, 32'h0000_0049);
    press();
    wait_on(0, 1'b1, 20, n);
    chk(32'(chan_active), 32'h0000_0003);
    for (int c = 0; c < NCH; c++) begin
      t = rnd();
      want_val[c] <= t[15:0];
    end
    repeat (10) @(posedge ref_clk);
    wait_on(1, 1'b1, 20, n);
    wait_on(1, 1'b1, 20, n);
    chk(32'(n), 32'(TK));
    chk(32'(rec_data[FAST_CH_A].cur), 32'(want_val[FAST_CH_A]));
    chk(32'(rec_data[FAST_CH_B].cur), 32'(want_val[FAST_CH_B]));
    chk(32'(rec_data[2].cur), 32'(ec[2]));
    chk(32'(rec_data[3].cur), 32'(ec[3]));
    wr(REG_CTRL, 32'h0000_0002);
    wait_on(0, 1'b0, 10, n);
    // edge mode, rising then falling, starting from the level that must not fire
    for (int e = 1; e >= 0; e--) begin
      want_din <= e[0];
      repeat (5) @(posedge ref_clk);
      wr(REG_CTRL, e ? 32'h0000_0015 : 32'h0000_0005);
      repeat (10) @(posedge ref_clk);
      chk(32'(recording), 32'h0000_0000);
      want_din <= !e[0];
      repeat (10) @(posedge ref_clk);
      chk(32'(recording), 32'h0000_0000);
      want_din <= e[0];
      wait_on(0, 1'b1, 10, n);
      chk(32'(recording), 32'h0000_0001);
      wr(REG_CTRL, 32'h0000_0002);
      wait_on(0, 1'b0, 10, n);
    end
    // calendar start, always set in the future
    t = sys_time + 32'h0000_0003 + (rnd() & 32'h0000_0007);
    wr(REG_TRIG_TIME, t);
    wr(REG_CTRL, 32'h0000_0001);
    q = sys_time;
    while (q != t) begin
      q++;
      repeat (4) @(posedge ref_clk);
      chk(32'(recording), 32'h0000_0000);
      sys_time <= q;
    end
    wait_on(0, 1'b1, 5, n);
    chk(32'(recording), 32'h0000_0001);
    wr(REG_CTRL, 32'h0000_0002);
    wait_on(0, 1'b0, 10, n);
    // duration stop, 2 ms
    wr(REG_DURATION, 32'h0000_0002);
    wr(REG_CTRL, 32'h0000_0029);
    press();
    wait_on(0, 1'b1, 20, n);
    wait_on(0, 1'b0, 200, n);
    t = 32'(2 * int'(MS_TICKS) * TK);
    chk(32'(n + 8 >= t && n <= t + 8), 32'h0000_0001);
    // logic AND: key then edge, ended by a 1 ms duration
    wr(REG_DURATION, 32'h0000_0001);
    wr(REG_CTRL, 32'h0000_0399);
    press();
    repeat (10) @(posedge ref_clk);
    chk(32'(recording), 32'h0000_0000);
    want_din <= 1'b1;
    wait_on(0, 1'b1, 10, n);
    chk(32'(recording), 32'h0000_0001);
    wait_on(0, 1'b0, 100, n);
    t = 32'(int'(MS_TICKS) * TK);
    chk(32'(n + 8 >= t && n <= t + 8), 32'h0000_0001);
    want_din <= 1'b0;
    end_of_test();
  end
endmodule
